// *** core/dbs_status_regs.sv ***
// device information and bus communication status registers
// assumes frame logic, monitors and interrupt pin logic all run on mclk
`timescale 1ns/1ns
`include "dbs_params.svh"
module dbs_status_regs
  import dbs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic soft_rst,
  input wire dbs_rd_req_t rd_req,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic crc_check_bypass,
  input wire dbs_clr_req_t clr_req,
  input wire logic crc_enabled,
  input wire logic crc_fail_evt,
  input wire logic crc_static_seq,
  input wire logic prior_fail_evt,
  input wire logic prior_sleep_evt,
  input wire logic software_development_mode,
  input wire logic wd_err_evt,
  input wire logic wd_service_ok,
  input wire logic spi_invalid_evt,
  input wire logic failure_evt,
  input wire logic lin_fail_evt,
  input wire logic [1:0] lin_fail_code,
  input wire logic can_fail_evt,
  input wire logic [1:0] can_fail_code,
  input wire logic selective_wake,
  input wire logic can_timeout_evt,
  input wire logic can_timeout_mask,
  input wire logic dev_normal_or_stop,
  input wire logic interrupt_output_b,
  input wire logic swu_cfg_err_evt,
  input wire logic [5:0] swu_err_count,
  input wire logic swu_enable_req,
  input wire dbs_can_mode_t can_mode,
  input wire logic can_uv_raw,
  output logic swu_enable_grant,
  output logic can_uv_comp_en,
  output logic can_tx_disable,
  output logic can_timeout_irq
);
  // ==========================================================
  // clear decode
  function automatic logic clr_hit(input dbs_clr_req_t r, input logic [6:0] a, input logic [15:0] m);
    return r.en && (r.addr == a) && (|(r.mask & m));
  endfunction

  wire clr_crc_fail = clr_hit(clr_req, `DBS_ADDR_DEV, `DBS_M_CRC_FAIL);
  wire clr_prior = clr_hit(clr_req, `DBS_ADDR_DEV, `DBS_M_PRIOR);
  wire clr_spi_fail = clr_hit(clr_req, `DBS_ADDR_DEV, `DBS_M_SPI_FAIL);
  wire clr_failure = clr_hit(clr_req, `DBS_ADDR_DEV, `DBS_M_FAILURE);
  wire clr_lin = clr_hit(clr_req, `DBS_ADDR_BUS, `DBS_M_LIN);
  wire clr_cto = clr_hit(clr_req, `DBS_ADDR_BUS, `DBS_M_CTO);
  wire clr_wkerr = clr_hit(clr_req, `DBS_ADDR_BUS, `DBS_M_WKERR);
  wire clr_can = clr_hit(clr_req, `DBS_ADDR_BUS, `DBS_M_CAN);
  wire clr_vcan = clr_hit(clr_req, `DBS_ADDR_BUS, `DBS_M_VCAN);

  // ==========================================================
  // device information fields
  logic crc_stat_ff;
  logic dev_mode_ff;
  dbs_prior_t prior_ff;
  dbs_prior_t nxt_prior;
  logic [1:0] wd_cnt_ff;
  logic [1:0] nxt_wd_cnt;
  logic crc_fail_q;
  logic spi_fail_q;
  logic failure_q;

  wire crc_fail_set = crc_fail_evt && !crc_static_seq; // RULE3

  assign nxt_prior = soft_rst ? DBS_PRIOR_CLEARED : // RULE11
                     prior_fail_evt ? DBS_PRIOR_RESTART : // RULE4
                     prior_sleep_evt ? DBS_PRIOR_SLEEP : // RULE6
                     clr_prior ? DBS_PRIOR_CLEARED : prior_ff; // RULE5

  // counter only moves on hardware events, host clears never reach it
  assign nxt_wd_cnt = soft_rst ? 2'h0 :
                      wd_err_evt ? ((wd_cnt_ff == `DBS_WD_MAX) ? `DBS_WD_MAX : 2'(wd_cnt_ff + 2'h1)) : // RULE8
                      wd_service_ok ? 2'h0 : wd_cnt_ff; // RULE8

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      crc_stat_ff <= 1'b0;
      dev_mode_ff <= 1'b0;
      prior_ff <= DBS_PRIOR_CLEARED;
      wd_cnt_ff <= 2'h0;
    end
    else
    begin
      crc_stat_ff <= crc_enabled && !soft_rst; // RULE2
      dev_mode_ff <= software_development_mode && !soft_rst; // RULE7
      prior_ff <= nxt_prior;
      wd_cnt_ff <= nxt_wd_cnt;
    end
  end

  dbs_sticky_bit u_crc_fail
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .soft_rst(soft_rst),
    .set_evt(crc_fail_set),
    .clr_req(clr_crc_fail),
    .q(crc_fail_q)
  );

  // only a host clear command or soft reset clears this flag
  dbs_sticky_bit u_spi_fail
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .soft_rst(soft_rst),
    .set_evt(spi_invalid_evt),
    .clr_req(clr_spi_fail), // RULE9
    .q(spi_fail_q)
  );

  dbs_sticky_bit u_failure
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .soft_rst(soft_rst),
    .set_evt(failure_evt),
    .clr_req(clr_failure),
    .q(failure_q)
  );

  // ==========================================================
  // bus communication fields
  logic [1:0] lin_ff;
  logic [1:0] nxt_lin;
  logic [1:0] can_ff;
  logic [1:0] nxt_can;
  logic cto_blk_ff;
  logic int_prev_ff;
  logic cto_q;
  logic wkerr_q;
  logic vcan_q;

  // first code is kept until cleared; a new event beats the clear
  assign nxt_lin = soft_rst ? 2'h0 : // RULE19
                   (lin_fail_evt && ((lin_ff == 2'h0) || clr_lin)) ? lin_fail_code : // RULE13
                   clr_lin ? 2'h0 : lin_ff;
  assign nxt_can = soft_rst ? 2'h0 :
                   (can_fail_evt && ((can_ff == 2'h0) || clr_can)) ? can_fail_code : // RULE16
                   clr_can ? 2'h0 : can_ff;

  wire cto_set = can_timeout_evt && selective_wake; // RULE20
  wire int_fall = int_prev_ff && !interrupt_output_b;
  wire cto_clr_eff = clr_cto && !cto_blk_ff; // RULE21
  wire wkerr_set = selective_wake && (swu_cfg_err_evt || (swu_err_count > `DBS_WU_ERR_LIMIT)); // RULE22
  wire can_uv_now = can_uv_raw && can_uv_comp_en;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lin_ff <= 2'h0;
      can_ff <= 2'h0;
      cto_blk_ff <= 1'b0;
      int_prev_ff <= 1'b1;
    end
    else
    begin
      lin_ff <= nxt_lin;
      can_ff <= nxt_can;
      cto_blk_ff <= !soft_rst && (cto_set || (cto_blk_ff && !int_fall)); // RULE21
      int_prev_ff <= interrupt_output_b;
    end
  end

  dbs_sticky_bit u_cto
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .soft_rst(soft_rst),
    .set_evt(cto_set),
    .clr_req(cto_clr_eff), // RULE14
    .q(cto_q)
  );

  dbs_sticky_bit u_wkerr
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .soft_rst(soft_rst),
    .set_evt(wkerr_set),
    .clr_req(clr_wkerr),
    .q(wkerr_q)
  );

  dbs_sticky_bit u_vcan
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .soft_rst(soft_rst),
    .set_evt(can_uv_now),
    .clr_req(clr_vcan),
    .q(vcan_q)
  );

  assign can_uv_comp_en = (can_mode == DBS_CAN_NORMAL) || (can_mode == DBS_CAN_RXONLY); // RULE18
  assign can_tx_disable = can_uv_now; // RULE17
  assign swu_enable_grant = swu_enable_req && !wkerr_q; // RULE15
  assign can_timeout_irq = cto_q && can_timeout_mask && dev_normal_or_stop; // RULE20

  // ==========================================================
  // read path
  dbs_dev_word_t dev_word;
  dbs_bus_word_t bus_word;
  logic [15:0] rd_data_ff;
  logic rd_valid_ff;

  assign dev_word = '{rsvd_hi: 6'h00, crc_stat: crc_stat_ff, crc_fail: crc_fail_q, // RULE1
                      prior_state_field: prior_ff, rsvd_5: 1'b0, software_development_mode: dev_mode_ff,
                      watchdog_failure_counter: wd_cnt_ff, spi_fail: spi_fail_q, failure: failure_q};
  assign bus_word = '{rsvd_hi: 9'h000, lin_fail: lin_ff, can_timeout_flag: cto_q, // RULE12
                      selective_wake_system_error: wkerr_q, can_fail: can_ff,
                      can_supply_undervoltage: vcan_q};

  wire rd_dev = rd_req.addr == `DBS_ADDR_DEV;
  wire rd_bus = rd_req.addr == `DBS_ADDR_BUS;
  wire [15:0] rd_mux = rd_dev ? dev_word : (rd_bus ? bus_word : 16'h0000);

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_data_ff <= rd_req.en ? rd_mux : rd_data_ff;
      rd_valid_ff <= rd_req.en;
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign crc_check_bypass = rd_req.en && rd_dev; // RULE10

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence dev_read_s;
    rd_req.en && rd_dev;
  endsequence
  sequence bus_read_s;
    rd_req.en && rd_bus;
  endsequence
  sequence cto_arm_s;
    cto_set ##1 !int_fall [*1];
  endsequence

  dev_reserved_a: assert property (dev_read_s |=> (rd_data & ~`DBS_DEV_RD_MASK) == 16'h0000) // RULE1
    else $error("device info reserved bits not zero");
  crc_stat_read_a: assert property (dev_read_s ##0 (!soft_rst && !$past(soft_rst) && $stable(crc_enabled))
                                    |=> rd_data[9] == $past(crc_enabled)) // RULE2
    else $error("crc state bit wrong on read");
  crc_static_a: assert property (!crc_fail_q && crc_static_seq && !soft_rst |=> !crc_fail_q) // RULE3
    else $error("crc fail set by static sequence");
  crc_fail_set_a: assert property (crc_fail_evt && !crc_static_seq && !soft_rst |=> crc_fail_q) // RULE3
    else $error("crc fail not latched");
  prior_code_a: assert property (prior_fail_evt && !soft_rst |=> prior_ff == DBS_PRIOR_RESTART) // RULE4
    else $error("prior state not restart code");
  prior_hold_a: assert property (!soft_rst && !prior_fail_evt && !prior_sleep_evt && !clr_prior
                                 |=> prior_ff == $past(prior_ff)) // RULE5
    else $error("prior state changed without clear");
  prior_sleep_a: assert property (prior_sleep_evt && !prior_fail_evt && !soft_rst
                                  |=> prior_ff == DBS_PRIOR_SLEEP) // RULE6
    else $error("prior state not sleep code");
  dev_mode_a: assert property (!soft_rst |=> dev_mode_ff == $past(software_development_mode)) // RULE7
    else $error("development mode bit not following mode");
  wd_sat_a: assert property (wd_err_evt && wd_cnt_ff == `DBS_WD_MAX && !soft_rst |=> wd_cnt_ff == `DBS_WD_MAX) // RULE8
    else $error("watchdog counter did not saturate");
  wd_noclr_a: assert property (!soft_rst && !wd_err_evt && !wd_service_ok |=> $stable(wd_cnt_ff)) // RULE8
    else $error("watchdog counter moved without cause");
  spi_fail_a: assert property (spi_fail_q && !clr_spi_fail && !soft_rst |=> spi_fail_q) // RULE9
    else $error("invalid command flag lost without clear");
  crc_bypass_a: assert property (dev_read_s |-> crc_check_bypass) // RULE10
    else $error("device info read not bypassing crc");
  soft_dev_a: assert property (soft_rst |=> dev_word == `DBS_DEV_RST && bus_word == `DBS_BUS_RST) // RULE11
    else $error("soft reset left status bits set");
  bus_reserved_a: assert property (bus_read_s |=> (rd_data & ~`DBS_BUS_RD_MASK) == 16'h0000) // RULE12
    else $error("bus status reserved bits not zero");
  lin_keep_a: assert property (lin_ff != 2'h0 && !clr_lin && !soft_rst |=> lin_ff == $past(lin_ff)) // RULE13
    else $error("lin failure code overwritten");
  cto_hold_a: assert property (cto_q && !clr_cto && !soft_rst |=> cto_q) // RULE14
    else $error("can timeout flag dropped");
  wake_block_a: assert property (wkerr_q |-> !swu_enable_grant) // RULE15
    else $error("selective wake enabled during system error");
  can_code_a: assert property (can_fail_evt && can_ff == 2'h0 && !soft_rst |=> can_ff == $past(can_fail_code)) // RULE16
    else $error("can failure code not latched");
  vcan_tx_a: assert property (can_uv_raw && can_uv_comp_en |-> can_tx_disable ##1 (vcan_q || $past(soft_rst))) // RULE17
    else $error("undervoltage did not disable transmitter");
  uv_comp_a: assert property (!(can_mode inside {DBS_CAN_NORMAL, DBS_CAN_RXONLY}) |-> !can_tx_disable) // RULE18
    else $error("undervoltage comparator active in wrong mode");
  bus_rst_a: assert property (soft_rst |=> lin_ff == 2'h0 && can_ff == 2'h0 && !cto_q) // RULE19
    else $error("soft reset left bus status set");
  cto_gate_a: assert property (!cto_q && !selective_wake && !soft_rst |=> !cto_q) // RULE20
    else $error("can timeout set without selective wake");
  cto_irq_a: assert property (cto_q && can_timeout_mask && dev_normal_or_stop |-> can_timeout_irq) // RULE20
    else $error("can timeout interrupt missing");
  cto_irq_off_a: assert property (!dev_normal_or_stop || !can_timeout_mask |-> !can_timeout_irq) // RULE20
    else $error("can timeout interrupt while masked");
  cto_guard_a: assert property (cto_arm_s ##0 (clr_cto && !soft_rst) |=> cto_q) // RULE21
    else $error("can timeout cleared before interrupt edge");
  wkerr_gate_a: assert property (!wkerr_q && !selective_wake && !soft_rst |=> !wkerr_q) // RULE22
    else $error("system error updated without selective wake");
  wkerr_cnt_a: assert property (selective_wake && swu_err_count > `DBS_WU_ERR_LIMIT && !soft_rst
                                |=> wkerr_q [*1]) // RULE22
    else $error("error count overflow not flagged");
  latch_hold_a: assert property (failure_q && !clr_failure && !soft_rst |=> failure_q) // RULE23
    else $error("failure flag lost without clear");
  spi_set_a: assert property (spi_invalid_evt && !soft_rst |=> spi_fail_q) // RULE9
    else $error("invalid command flag not latched");
  wd_inc_a: assert property (wd_err_evt && wd_cnt_ff != `DBS_WD_MAX && !soft_rst
                             |=> wd_cnt_ff == 2'($past(wd_cnt_ff) + 2'h1)) // RULE8
    else $error("watchdog counter did not count");
  rd_valid_a: assert property (rd_valid == $past(rd_req.en)) // RULE10
    else $error("read valid not one cycle after request");
endmodule

// *** core/dbs_sticky_bit.sv ***
// one latched status flag
// assumes set, clear and soft reset come from the mclk domain
`timescale 1ns/1ns
module dbs_sticky_bit
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic soft_rst,
  input wire logic set_evt,
  input wire logic clr_req,
  output logic q
);
  logic flag_ff;
  logic nxt_flag;

  // set wins over a clear in the same cycle
  assign nxt_flag = soft_rst ? 1'b0 : (set_evt ? 1'b1 : (clr_req ? 1'b0 : flag_ff)); // RULE23

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      flag_ff <= 1'b0;
    else
      flag_ff <= nxt_flag;
  end

  assign q = flag_ff;
endmodule

// *** include/dbs_params.svh ***
// constants for the device and bus status register bank
// assumes the frame logic hands over 7-bit register addresses
// Notes on behaviour
// RULE1: device info bits 15 to 10 always read zero.
// RULE2: bit 9 shows CRC checking on; bits 9 and 8 readable always.
// RULE3: bit 8 latches on CRC failure, never on the static CRC sequence.
// RULE4: bits 7:6 prior state: 00 cleared, 01 restart after failure, 10 sleep.
// RULE5: prior state holds until software clears it back to 00.
// RULE6: sleep attempt with wake flags pending also reports the sleep code.
// RULE7: bit 4 mirrors software development mode, read only.
// RULE8: bits 3:2 count watchdog failures, saturate at 3, self clearing only.
// RULE9: bit 1 latches on invalid command, cleared only by a host clear.
// RULE10: reading device info register skips the frame CRC check.
// RULE11: soft reset zeroes device info; restart keeps bits 9:6 and 4:0.
// RULE12: bus status bits 15 to 7 always read zero.
// RULE13: bits 6:5 latch one LIN failure code.
// RULE14: bit 4 latches on CAN timeout until software clears it.
// RULE15: bit 3 latches on wake system error and blocks selective wake enable.
// RULE16: bits 2:1 latch one CAN failure code.
// RULE17: bit 0 latches on CAN supply undervoltage; transmitter off meanwhile.
// RULE18: undervoltage comparator works only in CAN normal or receive only.
// RULE19: soft reset zeroes bus status; restart keeps bits 6:0.
// RULE20: CAN timeout sets only with selective wake on; interrupts unless masked. Code also needs dev_normal_or_stop for the interrupt.
// RULE21: CAN timeout clear ignored until next falling edge of interrupt output.
// RULE22: system error sets on config error or count above 32, wake enabled.
// RULE23: latched bits hold after cause goes, cleared only by host clear.
`ifndef DBS_PARAMS_SVH
`define DBS_PARAMS_SVH
`define DBS_ADDR_DEV 7'h42
`define DBS_ADDR_BUS 7'h43
`define DBS_DEV_RST 16'h0000
`define DBS_BUS_RST 16'h0000
`define DBS_DEV_RD_MASK 16'h03DF
`define DBS_BUS_RD_MASK 16'h007F
`define DBS_M_CRC_FAIL 16'h0100
`define DBS_M_PRIOR 16'h00C0
`define DBS_M_SPI_FAIL 16'h0002
`define DBS_M_FAILURE 16'h0001
`define DBS_M_LIN 16'h0060
`define DBS_M_CTO 16'h0010
`define DBS_M_WKERR 16'h0008
`define DBS_M_CAN 16'h0006
`define DBS_M_VCAN 16'h0001
`define DBS_WD_MAX 2'h3
`define DBS_WU_ERR_LIMIT 6'h20
`endif

// *** include/dbs_pkg.sv ***
// types for the device and bus status register bank
// assumes dbs_params.svh is on the include path
`include "dbs_params.svh"
package dbs_pkg;
  typedef enum logic [1:0]
  {
    DBS_PRIOR_CLEARED = 2'h0,
    DBS_PRIOR_RESTART = 2'h1,
    DBS_PRIOR_SLEEP = 2'h2
  } dbs_prior_t;

  typedef enum logic [1:0]
  {
    DBS_CAN_OFF = 2'h0,
    DBS_CAN_RXONLY = 2'h1,
    DBS_CAN_NORMAL = 2'h3,
    DBS_CAN_WAKE = 2'h2
  } dbs_can_mode_t;

  typedef struct packed
  {
    logic en;
    logic [6:0] addr;
  } dbs_rd_req_t;

  typedef struct packed
  {
    logic en;
    logic [6:0] addr;
    logic [15:0] mask;
  } dbs_clr_req_t;

  typedef struct packed
  {
    logic [5:0] rsvd_hi;
    logic crc_stat;
    logic crc_fail;
    logic [1:0] prior_state_field;
    logic rsvd_5;
    logic software_development_mode;
    logic [1:0] watchdog_failure_counter;
    logic spi_fail;
    logic failure;
  } dbs_dev_word_t;

  typedef struct packed
  {
    logic [8:0] rsvd_hi;
    logic [1:0] lin_fail;
    logic can_timeout_flag;
    logic selective_wake_system_error;
    logic [1:0] can_fail;
    logic can_supply_undervoltage;
  } dbs_bus_word_t;
endpackage

// *** verif/dbs_host_model.sv ***
// host side model: issues register reads and field clears
// assumes requests are taken on the rising edge of mclk
`timescale 1ns/1ns
module dbs_host_model
  import dbs_pkg::*;
(
  input wire logic mclk,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic crc_check_bypass,
  output dbs_rd_req_t rd_req,
  output dbs_clr_req_t clr_req
);
  initial
  begin
    rd_req = '0;
    clr_req = '0;
  end

  // ==========================================
  // read: request held over one edge, word taken after it
  task automatic read(input logic [6:0] addr, output logic [15:0] d, output logic bp, output logic v);
  begin
    @(posedge mclk);
    #1;
    rd_req = {1'b1, addr};
    #20;
    bp = crc_check_bypass;
    @(posedge mclk);
    #1;
    rd_req = '0;
    d = rd_data;
    v = rd_valid;
  end
  endtask

  // ==========================================
  // clear: addressed field mask, one edge
  task automatic clear(input logic [6:0] addr, input logic [15:0] mask);
  begin
    @(posedge mclk);
    #1;
    clr_req = {1'b1, addr, mask};
    @(posedge mclk);
    #1;
    clr_req = '0;
  end
  endtask
endmodule

// *** verif/testbench.sv ***
// self-checking bench for the status register bank
// assumes the host model drives reads and clears, bench drives monitors
`timescale 1ns/1ns
`include "dbs_params.svh"
module testbench
  import dbs_pkg::*;
;
  localparam logic [6:0] a_dev = `DBS_ADDR_DEV;
  localparam logic [6:0] a_bus = `DBS_ADDR_BUS;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic soft_rst, crc_enabled, crc_fail_evt, crc_static_seq, prior_fail_evt, prior_sleep_evt;
  logic software_development_mode, wd_err_evt, wd_service_ok, spi_invalid_evt, failure_evt;
  logic lin_fail_evt, can_fail_evt, selective_wake, can_timeout_evt, can_timeout_mask;
  logic dev_normal_or_stop, interrupt_output_b, swu_cfg_err_evt, swu_enable_req, can_uv_raw;
  logic [1:0] lin_fail_code, can_fail_code;
  logic [5:0] swu_err_count;
  dbs_can_mode_t can_mode = DBS_CAN_OFF;
  dbs_rd_req_t rd_req;
  dbs_clr_req_t clr_req;
  logic [15:0] rd_data;
  logic rd_valid, crc_check_bypass, swu_enable_grant, can_uv_comp_en, can_tx_disable, can_timeout_irq;
  int n_mismatch = 0;
  int checks = 0;

  always #25 mclk = ~mclk;

  dbs_status_regs i_dbs_status_regs (.mclk, .rst_b, .soft_rst, .rd_req, .rd_data, .rd_valid,
    .crc_check_bypass, .clr_req, .crc_enabled, .crc_fail_evt, .crc_static_seq, .prior_fail_evt,
    .prior_sleep_evt, .software_development_mode, .wd_err_evt, .wd_service_ok, .spi_invalid_evt,
    .failure_evt, .lin_fail_evt, .lin_fail_code, .can_fail_evt, .can_fail_code, .selective_wake,
    .can_timeout_evt, .can_timeout_mask, .dev_normal_or_stop, .interrupt_output_b, .swu_cfg_err_evt,
    .swu_err_count, .swu_enable_req, .can_mode, .can_uv_raw, .swu_enable_grant, .can_uv_comp_en,
    .can_tx_disable, .can_timeout_irq);

  dbs_host_model i_dbs_host_model (.mclk, .rd_data, .rd_valid, .crc_check_bypass, .rd_req, .clr_req);

  // ==========================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
  begin
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task automatic bit1(input logic seen, input logic exp);
  begin
    check({15'h0000, seen}, {15'h0000, exp});
  end
  endtask

  task automatic tick;
  begin
    @(posedge mclk);
    #1;
  end
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic bp;
    logic v;
  begin
    i_dbs_host_model.read(a, d, bp, v);
    check(d, exp);
    bit1(v, 1'b1);
    bit1(bp, a == 7'h42);
  end
  endtask

  task automatic clr(input logic [6:0] a, input logic [15:0] m);
  begin
    i_dbs_host_model.clear(a, m);
  end
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset_vals;
  begin
    rd(a_dev, 16'h0000);
    rd(a_bus, 16'h0000);
    rd(7'h7F, 16'h0000);
    $display("test reset values done");
  end
  endtask

  task automatic t_dev_flags;
  begin
    crc_enabled = 1'b1;
    crc_static_seq = 1'b1;
    crc_fail_evt = 1'b1;
    tick;
    crc_fail_evt = 1'b0;
    crc_static_seq = 1'b0;
    rd(a_dev, 16'h0200);
    crc_fail_evt = 1'b1;
    spi_invalid_evt = 1'b1;
    failure_evt = 1'b1;
    software_development_mode = 1'b1;
    tick;
    crc_fail_evt = 1'b0;
    spi_invalid_evt = 1'b0;
    failure_evt = 1'b0;
    repeat (3) tick;
    rd(a_dev, 16'h0313);
    clr(a_dev, 16'h0002);
    rd(a_dev, 16'h0311);
    clr(a_dev, 16'hFFFF);
    rd(a_dev, 16'h0210);
    crc_enabled = 1'b0;
    software_development_mode = 1'b0;
    rd(a_dev, 16'h0000);
    $display("test device flags done");
  end
  endtask

  task automatic t_prior;
  begin
    prior_sleep_evt = 1'b1;
    tick;
    prior_sleep_evt = 1'b0;
    repeat (8) tick;
    rd(a_dev, 16'h0080);
    clr(a_dev, 16'h0040);
    rd(a_dev, 16'h0000);
    prior_fail_evt = 1'b1;
    prior_sleep_evt = 1'b1;
    tick;
    prior_fail_evt = 1'b0;
    prior_sleep_evt = 1'b0;
    rd(a_dev, 16'h0040);
    clr(a_dev, 16'h0080);
    rd(a_dev, 16'h0000);
    $display("test prior state done");
  end
  endtask

  task automatic t_wd;
  begin
    for (int i = 1; i <= 4; i++)
    begin
      wd_err_evt = 1'b1;
      tick;
      wd_err_evt = 1'b0;
      rd(a_dev, (i > 3) ? 16'h000C : 16'(i << 2));
    end
    clr(a_dev, 16'hFFFF);
    rd(a_dev, 16'h000C);
    wd_service_ok = 1'b1;
    tick;
    wd_service_ok = 1'b0;
    rd(a_dev, 16'h0000);
    $display("test watchdog counter done");
  end
  endtask

  task automatic t_bus_codes;
  begin
    for (int c = 1; c <= 3; c++)
    begin
      lin_fail_code = 2'(c);
      can_fail_code = 2'(c);
      lin_fail_evt = 1'b1;
      can_fail_evt = 1'b1;
      tick;
      // a later code must not replace the first
      lin_fail_code = 2'((c % 3) + 1);
      can_fail_code = 2'((c % 3) + 1);
      tick;
      lin_fail_evt = 1'b0;
      can_fail_evt = 1'b0;
      rd(a_bus, 16'((c << 5) | (c << 1)));
      clr(a_bus, 16'h0066);
      rd(a_bus, 16'h0000);
    end
    $display("test bus codes done");
  end
  endtask

  task automatic t_cto;
  begin
    can_timeout_mask = 1'b1;
    dev_normal_or_stop = 1'b1;
    can_timeout_evt = 1'b1;
    tick;
    can_timeout_evt = 1'b0;
    rd(a_bus, 16'h0000);
    selective_wake = 1'b1;
    can_timeout_evt = 1'b1;
    tick;
    can_timeout_evt = 1'b0;
    tick;
    bit1(can_timeout_irq, 1'b1);
    can_timeout_mask = 1'b0;
    tick;
    bit1(can_timeout_irq, 1'b0);
    can_timeout_mask = 1'b1;
    dev_normal_or_stop = 1'b0;
    tick;
    bit1(can_timeout_irq, 1'b0);
    clr(a_bus, 16'h0010);
    rd(a_bus, 16'h0010);
    interrupt_output_b = 1'b0;
    tick;
    clr(a_bus, 16'h0010);
    rd(a_bus, 16'h0000);
    interrupt_output_b = 1'b1;
    $display("test can timeout done");
  end
  endtask

  task automatic t_wkerr;
  begin
    selective_wake = 1'b0;
    swu_enable_req = 1'b1;
    swu_cfg_err_evt = 1'b1;
    tick;
    swu_cfg_err_evt = 1'b0;
    rd(a_bus, 16'h0000);
    selective_wake = 1'b1;
    swu_err_count = 6'h20;
    repeat (3) tick;
    rd(a_bus, 16'h0000);
    bit1(swu_enable_grant, 1'b1);
    swu_err_count = 6'h21;
    tick;
    swu_err_count = 6'h00;
    rd(a_bus, 16'h0008);
    bit1(swu_enable_grant, 1'b0);
    clr(a_bus, 16'h0008);
    tick;
    bit1(swu_enable_grant, 1'b1);
    swu_cfg_err_evt = 1'b1;
    tick;
    swu_cfg_err_evt = 1'b0;
    rd(a_bus, 16'h0008);
    clr(a_bus, 16'h0008);
    selective_wake = 1'b0;
    $display("test wake system error done");
  end
  endtask

  task automatic t_can_uv;
    dbs_can_mode_t m [4] = '{DBS_CAN_OFF, DBS_CAN_RXONLY, DBS_CAN_NORMAL, DBS_CAN_WAKE};
    logic [3:0] on = 4'b0110;
  begin
    can_uv_raw = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      can_mode = m[i];
      tick;
      bit1(can_uv_comp_en, on[i]);
      bit1(can_tx_disable, on[i]);
      rd(a_bus, {15'h0000, on[i]});
      can_uv_raw = 1'b0;
      tick;
      bit1(can_tx_disable, 1'b0);
      rd(a_bus, {15'h0000, on[i]});
      clr(a_bus, 16'h0001);
      can_uv_raw = 1'b1;
    end
    can_uv_raw = 1'b0;
    $display("test can undervoltage done");
  end
  endtask

  task automatic t_soft;
  begin
    failure_evt = 1'b1;
    lin_fail_evt = 1'b1;
    lin_fail_code = 2'h1;
    tick;
    failure_evt = 1'b0;
    lin_fail_evt = 1'b0;
    rd(a_dev, 16'h0001);
    rd(a_bus, 16'h0020);
    soft_rst = 1'b1;
    tick;
    soft_rst = 1'b0;
    rd(a_dev, 16'h0000);
    rd(a_bus, 16'h0000);
    $display("test soft reset done");
  end
  endtask

  // ==========================================
  // run control
  task automatic conclude;
  begin
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  initial
  begin
    {soft_rst, crc_enabled, crc_fail_evt, crc_static_seq, prior_fail_evt, prior_sleep_evt} = '0;
    {software_development_mode, wd_err_evt, wd_service_ok, spi_invalid_evt, failure_evt} = '0;
    {lin_fail_evt, can_fail_evt, selective_wake, can_timeout_evt, can_timeout_mask} = '0;
    {dev_normal_or_stop, swu_cfg_err_evt, swu_enable_req, can_uv_raw} = '0;
    {lin_fail_code, can_fail_code, swu_err_count} = '0;
    interrupt_output_b = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    t_reset_vals;
    t_dev_flags;
    t_prior;
    t_wd;
    t_bus_codes;
    t_cto;
    t_wkerr;
    t_can_uv;
    t_soft;
    conclude;
  end

  // hang guard, far beyond the expected run length
  initial
  begin
    #2000000;
    n_mismatch++;
    conclude;
  end
endmodule
